// ---- design/rsld_top.sv ----
/*
  reset source combiner and supply level detector with an apb slave.
  assumes comparator outputs and the option bit are synchronous to i_clk.
*/
`timescale 1ns/1ps
`include "rsld_defs.svh"

module rsld_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // reset sources
  input wire logic i_ext_reset_n_pin,
  input wire logic i_opt_drop_reset_sel,
  input wire logic i_wdt_overflow,
  input wire logic i_drop_below,
  // supply level detector comparator
  input wire logic i_det_below,
  output logic o_det_enable,
  output logic [1:0] o_det_level,
  // system outputs
  output logic o_sys_reset,
  output logic o_irq
);

  rsld_pkg::rsld_top_t q, d;

  logic pin_sync;
  logic pin_low;
  logic wdt_fire;
  logic clr;
  logic setup;
  logic access;
  logic wr;
  rsld_pkg::rsld_reg_t sel;
  logic [`RSLD_IRQ_W-1:0] irq_stat;
  logic [`RSLD_IRQ_W-1:0] irq_mask;
  logic [`RSLD_IRQ_W-1:0] irq_event;
  logic [`RSLD_IRQ_W-1:0] irq_clear;
  logic mask_we;
  logic [31:0] rdata;

  // address decode, used for reads and writes
  function automatic rsld_pkg::rsld_reg_t rsld_decode(input logic [31:0] addr);
    case (addr)
      `RSLD_OFF_DET_CTRL: rsld_decode = rsld_pkg::RSLD_REG_DET;
      `RSLD_OFF_BT_CTRL: rsld_decode = rsld_pkg::RSLD_REG_BT;
      `RSLD_OFF_IRQ_STAT: rsld_decode = rsld_pkg::RSLD_REG_STAT;
      `RSLD_OFF_IRQ_MASK: rsld_decode = rsld_pkg::RSLD_REG_MASK;
      `RSLD_OFF_RST_STAT: rsld_decode = rsld_pkg::RSLD_REG_RST;
      default: rsld_decode = rsld_pkg::RSLD_REG_NONE;
    endcase
  endfunction

  // external pin into the clock domain
  rsld_sync u_pin_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(i_ext_reset_n_pin),
    .o_sync(pin_sync)
  );

  // sticky events and mask
  rsld_irq u_irq (
    .i_clk(i_clk),
    .i_reset(clr),
    .i_event(irq_event),
    .i_clear(irq_clear),
    .i_mask_we(mask_we),
    .i_mask_wdata(i_pwdata[`RSLD_IRQ_W-1:0]),
    .o_status(irq_stat),
    .o_mask(irq_mask)
  );

  // bus phases and reset sources
  always_comb begin
    pin_low = ~pin_sync;
    wdt_fire = i_wdt_overflow & ~q.wdt_off;
    clr = i_reset | q.sys_rst;
    setup = i_psel & ~i_penable;
    access = i_psel & i_penable & q.pready;
    sel = rsld_decode(i_paddr);
    wr = access & i_pwrite & ~q.pslverr;
    mask_we = wr & (sel == rsld_pkg::RSLD_REG_MASK);
    irq_clear = (wr && sel == rsld_pkg::RSLD_REG_STAT) ? i_pwdata[`RSLD_IRQ_W-1:0] : `RSLD_IRQ_RST;
    irq_event[`RSLD_IRQ_LOW] = q.det_en & i_det_below;
    irq_event[`RSLD_IRQ_OK] = q.flag & ~i_det_below & q.det_en;
  end

  // read data mux
  always_comb begin
    rdata = 32'h0000_0000;
    case (sel)
      rsld_pkg::RSLD_REG_DET: begin
        rdata[`RSLD_DET_EN_BIT] = q.det_en;
        rdata[`RSLD_DET_FLAG_BIT] = q.flag;
        rdata[`RSLD_DET_LVL_MSB:`RSLD_DET_LVL_LSB] = q.det_lvl;
      end
      rsld_pkg::RSLD_REG_BT: begin
        rdata[`RSLD_BT_STAB_MSB:`RSLD_BT_STAB_LSB] = q.bt_stab;
      end
      rsld_pkg::RSLD_REG_STAT: rdata[`RSLD_IRQ_W-1:0] = irq_stat;
      rsld_pkg::RSLD_REG_MASK: rdata[`RSLD_IRQ_W-1:0] = irq_mask;
      rsld_pkg::RSLD_REG_RST: begin
        rdata[`RSLD_RST_OPT_BIT] = q.opt;
        rdata[`RSLD_RST_PIN_BIT] = pin_low;
        rdata[`RSLD_RST_DROP_BIT] = i_drop_below;
        rdata[`RSLD_RST_WOFF_BIT] = q.wdt_off;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  // next state
  always_comb begin
    d = q;
    // option bit caught while power-on reset is held
    if (i_reset) begin
      d.opt = i_opt_drop_reset_sel;
    end
    // watchdog stretch counter
    if (wdt_fire) begin
      d.hold = 3'(`RSLD_WDT_HOLD_CYC);
    end else if (q.hold != 3'h0) begin
      d.hold = q.hold - 3'h1;
    end
    // power-on reset empties the stretch counter, which has no other reset
    if (i_reset) begin
      d.hold = 3'h0;
    end
    // merged system reset, source chosen by the option bit
    d.sys_rst = i_reset | (~q.opt & pin_low) | (q.opt & i_drop_below)
      | wdt_fire | (q.hold != 3'h0);
    // flag tracks the comparator, never the bus
    d.flag = q.det_en & i_det_below;
    d.irq = |(irq_stat & irq_mask);
    // apb: answer prepared in setup, ready in access
    if (setup) begin
      d.pready = 1'h1;
      d.prdata = rdata;
      d.pslverr = (sel == rsld_pkg::RSLD_REG_NONE);
    end else if (access) begin
      d.pready = 1'h0;
    end
    // register writes
    if (wr && sel == rsld_pkg::RSLD_REG_DET) begin
      d.det_en = i_pwdata[`RSLD_DET_EN_BIT];
      d.det_lvl = i_pwdata[`RSLD_DET_LVL_MSB:`RSLD_DET_LVL_LSB];
    end
    if (wr && sel == rsld_pkg::RSLD_REG_BT) begin
      d.bt_stab = i_pwdata[`RSLD_BT_STAB_MSB:`RSLD_BT_STAB_LSB];
      d.wdt_off = (i_pwdata[`RSLD_BT_KEY_MSB:`RSLD_BT_KEY_LSB] == `RSLD_BT_WDT_OFF_KEY);
    end
    // any reset restores control defaults
    if (clr) begin
      d.det_en = `RSLD_DET_EN_RST;
      d.det_lvl = `RSLD_DET_LVL_RST;
      d.bt_stab = `RSLD_BT_STAB_RST;
      d.wdt_off = `RSLD_BT_WDT_OFF_RST;
      d.pready = 1'h0;
      d.pslverr = 1'h0;
      d.prdata = 32'h0000_0000;
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    q <= d;
  end

  // outputs straight from flops
  assign o_sys_reset = q.sys_rst;
  assign o_det_enable = q.det_en;
  assign o_det_level = q.det_lvl;
  assign o_prdata = q.prdata;
  assign o_pready = q.pready;
  assign o_pslverr = q.pslverr;
  assign o_irq = q.irq;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_drop_hold;
    q.opt && i_drop_below |=> o_sys_reset;
  endproperty
  a_drop_hold: assert property (p_drop_hold) else $error("supply drop did not hold reset");

  property p_pin_reset;
    (!q.opt && !i_ext_reset_n_pin) [*3] |=> o_sys_reset;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin low did not reset after sync");

  property p_source_select;
    !q.opt && !pin_low && !wdt_fire && q.hold == 3'h0 |=> !o_sys_reset;
  endproperty
  a_source_select: assert property (p_source_select) else $error("unselected source reset the system");

  property p_wdt_stretch;
    wdt_fire && !q.sys_rst |=> o_sys_reset [*5];
  endproperty
  a_wdt_stretch: assert property (p_wdt_stretch) else $error("watchdog reset too short");

  property p_wdt_off;
    wr && sel == rsld_pkg::RSLD_REG_BT && !clr
      && i_pwdata[`RSLD_BT_KEY_MSB:`RSLD_BT_KEY_LSB] == `RSLD_BT_WDT_OFF_KEY |=> q.wdt_off;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("key did not disable watchdog");

  property p_det_write;
    wr && sel == rsld_pkg::RSLD_REG_DET && !clr
      |=> o_det_enable == $past(i_pwdata[`RSLD_DET_EN_BIT])
      && o_det_level == $past(i_pwdata[`RSLD_DET_LVL_MSB:`RSLD_DET_LVL_LSB]);
  endproperty
  a_det_write: assert property (p_det_write) else $error("detector control write lost");

  property p_flag_follow;
    q.det_en && !clr ##1 q.det_en |-> q.flag == $past(i_det_below);
  endproperty
  a_flag_follow: assert property (p_flag_follow) else $error("flag does not follow comparator");

  property p_flag_ro;
    wr && sel == rsld_pkg::RSLD_REG_DET && i_pwdata[`RSLD_DET_FLAG_BIT] && !i_det_below |=> !q.flag;
  endproperty
  a_flag_ro: assert property (p_flag_ro) else $error("flag written by software");

  property p_low_irq;
    q.det_en && i_det_below && irq_mask[`RSLD_IRQ_LOW] && !clr && !mask_we |=> ##1 o_irq;
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("low supply interrupt missing");

  property p_defaults;
    q.sys_rst |=> !o_det_enable && o_det_level == `RSLD_DET_LVL_RST && !q.wdt_off;
  endproperty
  a_defaults: assert property (p_defaults) else $error("reset left control registers set");

  // release, refusal and sticky status
  property p_drop_release;
    q.opt && !i_drop_below && !wdt_fire && q.hold == 3'h0 |=> !o_sys_reset;
  endproperty
  a_drop_release: assert property (p_drop_release) else $error("reset held after supply recovered");

  property p_pin_sync_delay;
    !q.opt && $fell(i_ext_reset_n_pin) && !pin_low && !wdt_fire && q.hold == 3'h0 |=> !o_sys_reset;
  endproperty
  a_pin_sync_delay: assert property (p_pin_sync_delay) else $error("pin acted before synchronisation");

  property p_flag_off;
    !q.det_en |=> !q.flag;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("disabled detector raised the flag");

  property p_low_sticky;
    irq_stat[`RSLD_IRQ_LOW] && !clr && !irq_clear[`RSLD_IRQ_LOW] |=> irq_stat[`RSLD_IRQ_LOW];
  endproperty
  a_low_sticky: assert property (p_low_sticky) else $error("low supply status lost without clear");

  property p_set_wins;
    irq_event[`RSLD_IRQ_LOW] && irq_clear[`RSLD_IRQ_LOW] && !clr |=> irq_stat[`RSLD_IRQ_LOW];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a low supply event");

  property p_ok_clear;
    irq_clear[`RSLD_IRQ_OK] && !irq_event[`RSLD_IRQ_OK] && !clr |=> !irq_stat[`RSLD_IRQ_OK];
  endproperty
  a_ok_clear: assert property (p_ok_clear) else $error("recovered status not cleared by write");

  property p_bus_defaults;
    q.sys_rst |=> !o_pready && !o_pslverr;
  endproperty
  a_bus_defaults: assert property (p_bus_defaults) else $error("reset left a bus answer standing");

  // main scenarios
  c_wdt: cover property (wdt_fire ##1 o_sys_reset);
  c_pin: cover property (!q.opt && pin_low ##1 o_sys_reset);
  c_irq: cover property ($rose(o_irq));
  c_write: cover property (wr && sel == rsld_pkg::RSLD_REG_DET);
  c_drop: cover property (q.opt && i_drop_below ##1 o_sys_reset);

endmodule

// ---- design/rsld_defs.svh ----
/*
  constants of the reset source and supply level detector block:
  register offsets, field positions, reset values and timing counts.
  assumes inclusion by the package and the design modules.
*/
`ifndef RSLD_DEFS_SVH
`define RSLD_DEFS_SVH

// register byte offsets on the apb slave
`define RSLD_OFF_DET_CTRL 32'h0000_0000
`define RSLD_OFF_BT_CTRL 32'h0000_0004
`define RSLD_OFF_IRQ_STAT 32'h0000_0008
`define RSLD_OFF_IRQ_MASK 32'h0000_000c
`define RSLD_OFF_RST_STAT 32'h0000_0010

// detector_control_reg fields
`define RSLD_DET_EN_BIT 7
`define RSLD_DET_FLAG_BIT 5
`define RSLD_DET_LVL_MSB 1
`define RSLD_DET_LVL_LSB 0
`define RSLD_DET_EN_RST 1'h0
`define RSLD_DET_LVL_RST 2'h0

// basic_timer_control_reg fields
`define RSLD_BT_KEY_MSB 7
`define RSLD_BT_KEY_LSB 4
`define RSLD_BT_STAB_MSB 3
`define RSLD_BT_STAB_LSB 0
`define RSLD_BT_WDT_OFF_KEY 4'ha
`define RSLD_BT_STAB_RST 4'h0
`define RSLD_BT_WDT_OFF_RST 1'h0

// interrupt status and mask bits
`define RSLD_IRQ_W 2
`define RSLD_IRQ_LOW 0
`define RSLD_IRQ_OK 1
`define RSLD_IRQ_RST 2'h0

// reset status register bits
`define RSLD_RST_OPT_BIT 0
`define RSLD_RST_PIN_BIT 1
`define RSLD_RST_DROP_BIT 2
`define RSLD_RST_WOFF_BIT 3

// idle level of the external reset pin
`define RSLD_PIN_IDLE 1'h1

// watchdog reset stretch: time and derived cycles (rounded up)
`define RSLD_CLK_NS 10
`define RSLD_WDT_HOLD_NS 40
`define RSLD_WDT_HOLD_CYC ((`RSLD_WDT_HOLD_NS + `RSLD_CLK_NS - 1) / `RSLD_CLK_NS)

`endif

// ---- design/rsld_pkg.sv ----
/*
  types of the reset source and supply level detector block.
  assumes rsld_defs.svh is on the include path.
*/
`include "rsld_defs.svh"

package rsld_pkg;

  // register selected by an apb address
  typedef enum logic [2:0] {
    RSLD_REG_DET,
    RSLD_REG_BT,
    RSLD_REG_STAT,
    RSLD_REG_MASK,
    RSLD_REG_RST,
    RSLD_REG_NONE
  } rsld_reg_t;

  // two-stage synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
  } rsld_sync_t;

  // interrupt status and mask state
  typedef struct packed {
    logic [`RSLD_IRQ_W-1:0] stat;
    logic [`RSLD_IRQ_W-1:0] mask;
  } rsld_irq_t;

  // top-level state
  typedef struct packed {
    logic opt;
    logic sys_rst;
    logic [2:0] hold;
    logic det_en;
    logic [1:0] det_lvl;
    logic flag;
    logic [3:0] bt_stab;
    logic wdt_off;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } rsld_top_t;

endpackage

// ---- design/rsld_sync.sv ----
/*
  two flip-flop synchroniser for the external reset pin.
  assumes the pin already passed the schmitt-trigger pad.
*/
`timescale 1ns/1ps
`include "rsld_defs.svh"

module rsld_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // pin and synced level
  input wire logic i_async,
  output logic o_sync
);

  rsld_pkg::rsld_sync_t q, d;

  // shift chain, first stage read only by the second
  always_comb begin
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  // reset to the asserted level, so a pin still held low shows no two-cycle release
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q.s1 <= ~`RSLD_PIN_IDLE;
      q.s2 <= ~`RSLD_PIN_IDLE;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.s2;

endmodule

// ---- design/rsld_irq.sv ----
/*
  sticky interrupt status with write-one-to-clear and a mask.
  assumes clears are single-clock synchronous pulses and events are synchronous levels or pulses.
*/
`timescale 1ns/1ps
`include "rsld_defs.svh"

module rsld_irq (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // events and software access
  input wire logic [`RSLD_IRQ_W-1:0] i_event,
  input wire logic [`RSLD_IRQ_W-1:0] i_clear,
  input wire logic i_mask_we,
  input wire logic [`RSLD_IRQ_W-1:0] i_mask_wdata,
  // state
  output logic [`RSLD_IRQ_W-1:0] o_status,
  output logic [`RSLD_IRQ_W-1:0] o_mask
);

  rsld_pkg::rsld_irq_t q, d;

  // set beats clear in the same cycle
  always_comb begin
    d = q;
    d.stat = (q.stat & ~i_clear) | i_event;
    if (i_mask_we) begin
      d.mask = i_mask_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q.stat <= `RSLD_IRQ_RST;
      q.mask <= `RSLD_IRQ_RST;
    end else begin
      q <= d;
    end
  end

  assign o_status = q.stat;
  assign o_mask = q.mask;

endmodule

// ---- tb/rsld_far_side.sv ----
/*
  far-side model: external reset pin driver and the two supply comparators.
  assumes the supply is given in millivolts by the testbench.
*/
`timescale 1ns/1ps

module rsld_far_side #(
  parameter int HOLD_CYC = 8,
  parameter int POR_MV = 1000,
  parameter int DROP_MV = 1900
) (
  // clock
  input wire logic i_clk,
  // stimulus from the testbench
  input wire logic [15:0] i_supply_mv,
  input wire logic i_pin_req_n,
  // detector set-up from the block
  input wire logic i_det_enable,
  input wire logic [1:0] i_det_level,
  // comparator and pin outputs
  output logic o_ext_reset_n_pin,
  output logic o_drop_below,
  output logic o_det_below
);
  int hold_cnt = HOLD_CYC;
  logic [15:0] lvl_mv;

  // pin stays low a while after the supply is good
  always @(posedge i_clk) begin
    if (i_supply_mv < POR_MV) hold_cnt <= HOLD_CYC;
    else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
  end

  // detection threshold chosen by the level field
  always_comb begin
    case (i_det_level)
      2'h0: lvl_mv = 16'h0834;
      2'h1: lvl_mv = 16'h09c4;
      2'h2: lvl_mv = 16'h0c80;
      default: lvl_mv = 16'h1004;
    endcase
  end

  // comparators; a disabled detector output is meaningless
  assign o_ext_reset_n_pin = i_pin_req_n && (hold_cnt == 0);
  assign o_drop_below = (i_supply_mv < DROP_MV);
  assign o_det_below = i_det_enable ? (i_supply_mv < lvl_mv) : 1'b1;
endmodule

// ---- tb/testbench.sv ----
/*
  testbench for rsld_top: apb register tests and reset source scenarios.
  assumes the far-side model rsld_far_side and the defines header.
*/
`timescale 1ns/1ps
`include "rsld_defs.svh"

module testbench;
  logic i_clk, i_reset, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic pin_req_n, opt, wdt, pin_n, drop, det_below, det_en, sys_rst, irq;
  logic [1:0] det_lvl;
  logic [15:0] supply;
  int n_errors = 0;
  int cmp_count = 0;
  int n;

  // block and far side
  rsld_top u_rsld_top (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_ext_reset_n_pin(pin_n), .i_opt_drop_reset_sel(opt), .i_wdt_overflow(wdt),
    .i_drop_below(drop), .i_det_below(det_below), .o_det_enable(det_en), .o_det_level(det_lvl),
    .o_sys_reset(sys_rst), .o_irq(irq));
  rsld_far_side u_rsld_far_side (.i_clk(i_clk), .i_supply_mv(supply), .i_pin_req_n(pin_req_n),
    .i_det_enable(det_en), .i_det_level(det_lvl), .o_ext_reset_n_pin(pin_n), .o_drop_below(drop),
    .o_det_below(det_below));

  // 100 mhz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one apb transfer, setup then access until pready
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, x, r);
    chk({nm, " err"}, 32'h0000_0000, {31'h0, e});
  endtask

  // edges until o_sys_reset shows lvl, bounded by lim
  task automatic wait_rst(input logic lvl, input int lim, output int k);
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (sys_rst !== lvl && k < lim);
  endtask

  task automatic pulse_wdt();
    @(posedge i_clk);
    wdt <= 1'b1;
    @(posedge i_clk);
    wdt <= 1'b0;
  endtask

  task automatic set_supply(input logic [15:0] mv);
    @(posedge i_clk);
    supply <= mv;
  endtask

  // hang guard
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    i_reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pin_req_n = 1'b1;
    opt = 1'b0;
    wdt = 1'b0;
    supply = 16'h0bb8;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    wait_rst(1'b0, 40, n);
    for (int i = 0; i < 5; i++) rd_chk("reset value", 32'(4 * i), 32'h0000_0000);
    apb(1'b0, 32'h0000_0014, 32'h0000_0000, r, e);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, r);
    // detector off: no flag though the comparator says below
    wr(`RSLD_OFF_DET_CTRL, 32'h0000_0023);
    rd_chk("det off", `RSLD_OFF_DET_CTRL, 32'h0000_0003);
    for (int l = 0; l < 4; l++) begin
      wr(`RSLD_OFF_DET_CTRL, 32'h0000_00a0 | 32'(l));
      rd_chk("det_ctrl", `RSLD_OFF_DET_CTRL, 32'h0000_0080 | 32'(l) | (l >= 2 ? 32'h0000_0020 : 32'h0000_0000));
      chk("det_level", 32'(l), {30'h0, det_lvl});
      chk("det_enable", 32'h0000_0001, {31'h0, det_en});
    end
    // low-supply interrupt, masked then unmasked, clear while still low
    rd_chk("irq status", `RSLD_OFF_IRQ_STAT, 32'h0000_0001);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    wr(`RSLD_OFF_IRQ_MASK, 32'h0000_0001);
    rd_chk("irq mask", `RSLD_OFF_IRQ_MASK, 32'h0000_0001);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    wr(`RSLD_OFF_IRQ_STAT, 32'h0000_0001);
    rd_chk("irq reset", `RSLD_OFF_IRQ_STAT, 32'h0000_0001);
    set_supply(16'h1388);
    rd_chk("flag clear", `RSLD_OFF_DET_CTRL, 32'h0000_0083);
    rd_chk("recovered", `RSLD_OFF_IRQ_STAT, 32'h0000_0003);
    wr(`RSLD_OFF_IRQ_STAT, 32'h0000_0003);
    rd_chk("w1c", `RSLD_OFF_IRQ_STAT, 32'h0000_0000);
    chk("irq low", 32'h0000_0000, {31'h0, irq});
    // watchdog overflow resets and clears registers
    pulse_wdt();
    wait_rst(1'b1, 10, n);
    chk("wdt rise", 32'h0000_0001, 32'(n));
    wait_rst(1'b0, 10, n);
    chk("wdt hold", 32'h0000_0005, 32'(n));
    rd_chk("det after wdt", `RSLD_OFF_DET_CTRL, 32'h0000_0000);
    rd_chk("mask after wdt", `RSLD_OFF_IRQ_MASK, 32'h0000_0000);
    wr(`RSLD_OFF_BT_CTRL, 32'h0000_00a5);
    rd_chk("bt_ctrl", `RSLD_OFF_BT_CTRL, 32'h0000_0005);
    rd_chk("wdt off", `RSLD_OFF_RST_STAT, 32'h0000_0008);
    pulse_wdt();
    wait_rst(1'b1, 8, n);
    chk("wdt ignored", 32'h0000_0008, 32'(n));
    // external pin through the synchroniser
    @(posedge i_clk);
    pin_req_n <= 1'b0;
    wait_rst(1'b1, 10, n);
    chk("pin rise", 32'h0000_0004, 32'(n));
    repeat (5) @(posedge i_clk);
    chk("pin hold", 32'h0000_0001, {31'h0, sys_rst});
    pin_req_n <= 1'b1;
    wait_rst(1'b0, 10, n);
    chk("pin fall", 32'h0000_0001, {31'h0, n > 1 && n < 7});
    rd_chk("rst stat", `RSLD_OFF_RST_STAT, 32'h0000_0000);
    set_supply(16'h05dc);
    wait_rst(1'b1, 8, n);
    chk("drop ignored", 32'h0000_0008, 32'(n));
    rd_chk("drop seen", `RSLD_OFF_RST_STAT, 32'h0000_0004);
    set_supply(16'h0ce4);
    // second reset with the supply-drop option
    @(posedge i_clk);
    i_reset <= 1'b1;
    opt <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    wait_rst(1'b0, 20, n);
    rd_chk("option", `RSLD_OFF_RST_STAT, 32'h0000_0001);
    @(posedge i_clk);
    pin_req_n <= 1'b0;
    wait_rst(1'b1, 8, n);
    chk("pin ignored", 32'h0000_0008, 32'(n));
    rd_chk("pin seen", `RSLD_OFF_RST_STAT, 32'h0000_0003);
    @(posedge i_clk);
    pin_req_n <= 1'b1;
    set_supply(16'h05dc);
    wait_rst(1'b1, 10, n);
    chk("drop rise", 32'h0000_0002, 32'(n));
    repeat (8) @(posedge i_clk);
    chk("drop hold", 32'h0000_0001, {31'h0, sys_rst});
    supply <= 16'h0ce4;
    wait_rst(1'b0, 10, n);
    chk("drop fall", 32'h0000_0001, {31'h0, n > 1 && n < 5});
    tally_and_finish();
  end
endmodule
